// ===== pkg/dpsc_pkg.sv
// Shared constants and types for the dual pot serial control front end.
// Assumes a 200 MHz core clock and an SPI link clock that runs only in frames.
// Functional notes
// - One 6-bit wiper register per pot.
// - Four 6-bit stored slots per pot.
// - Power-up copies first slot into wiper.
// - Link works in modes (0,0) and (1,1).
// - Input bits sampled on rising clock edge.
// - Output changes on falling clock edge.
// - Respond only when address matches straps.
// - Chip select high floats output, standby.
// - Select rise after write starts cycle.
// - Protect low blocks slot writes only.
// - Protect high means normal operation.
// - Protect falling mid-frame abandons write.
// - Started write cycle always completes.
// - Paused: output floats, input ignored.
// - Resume continues without retransmission.
// - First byte after select is instruction.
// - Exactly one tap per pot connected.
package dpsc_pkg;

  // ----------------------------------------------------------------
  // Sizes and instruction layout
  // ----------------------------------------------------------------
  localparam int         POT_COUNT  = 2;     // Potentiometers in the device.
  localparam int         SLOT_COUNT = 4;     // Stored settings per pot.
  localparam int         WIPER_W    = 6;     // Wiper and slot width.
  localparam int         TAP_COUNT  = 64;    // Taps per pot.
  localparam int         OP_POS     = 5;     // Opcode field, bits 7:5.
  localparam int         ADDR_POS   = 3;     // Device address, bits 4:3.
  localparam int         POT_POS    = 2;     // Pot select, bit 2.
  localparam int         SLOT_POS   = 0;     // Slot index, bits 1:0.

  // Opcodes of the six operations.
  localparam logic [2:0] OP_READ_WIPER  = 3'h0;
  localparam logic [2:0] OP_WRITE_WIPER = 3'h1;
  localparam logic [2:0] OP_READ_SLOT   = 3'h2;
  localparam logic [2:0] OP_WRITE_SLOT  = 3'h3;
  localparam logic [2:0] OP_RECALL      = 3'h4;
  localparam logic [2:0] OP_STORE       = 3'h5;

  // Frame lengths in bits; the counter saturates at the overflow mark.
  localparam logic [4:0] LEN_INSTR = 5'h08;
  localparam logic [4:0] LEN_DATA  = 5'h10;
  localparam logic [4:0] LEN_OVER  = 5'h11;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [5:0] SLOT_RESET = 6'h20;  // Slot content after reset.
  localparam logic [5:0] SYNC_RESET = 6'h07;  // Select, protect, pause idle high.
  localparam int         CLK_PERIOD_NS      = 5;
  localparam int         WRITE_CYCLE_NS     = 5000000;
  localparam int         WRITE_CYCLE_CYCLES = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         BUSY_W             = 20;

  // Core sequencer states.
  typedef enum logic [1:0] {ST_RECALL, ST_IDLE, ST_BUSY} dpsc_state_t;

  typedef logic [POT_COUNT-1:0][WIPER_W-1:0]                 dpsc_wipers_t;
  typedef logic [POT_COUNT-1:0][SLOT_COUNT-1:0][WIPER_W-1:0] dpsc_slots_t;

endpackage

// ===== pkg/dpsc_link_if.sv
// Carrier between the link clock logic and the core clock logic.
// Assumes words toward the core are stable whenever chip select is high.
`timescale 1ns/10ps
interface dpsc_link_if;
  import dpsc_pkg::*;
  logic [7:0]   instrByte;   // Instruction byte of the last frame.
  logic [7:0]   dataByte;    // Data byte of the last frame.
  logic [4:0]   frameLen;    // Bits taken in the last frame.
  logic         readPhase;   // Level: read data is being shifted out.
  logic         soBit;       // Serial output bit, falling edge register.
  dpsc_wipers_t wiperVal;    // Quasi-static wiper values for reads.
  dpsc_slots_t  slotVal;     // Quasi-static slot values for reads.
  logic [1:0]   strapAddr;   // Synchronised address straps.

  modport link (output instrByte, dataByte, frameLen, readPhase, soBit,
                input  wiperVal, slotVal, strapAddr);
  modport core (input  instrByte, dataByte, frameLen, readPhase, soBit,
                output wiperVal, slotVal, strapAddr);
endinterface

// ===== design/dpsc_spi_link.sv
// SPI shift logic clocked by the serial clock of the controller.
// Assumes select, pause and input are stable around each serial clock edge.
`timescale 1ns/10ps
module dpsc_spi_link (
  input  wire logic  sck,
  input  wire logic  reset,
  input  wire logic  csN,
  input  wire logic  si,
  input  wire logic  holdN,
  dpsc_link_if.link  lnk
);
  import dpsc_pkg::*;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  logic       frameClr;                 // Select high or reset clears the frame.
  logic [4:0] bitCnt_reg, bitCnt_next;  // Bits in this frame.
  logic [6:0] shift_reg, shift_next;    // Partial byte.
  logic [7:0] instr_reg, instr_next;    // Captured instruction.
  logic [7:0] data_reg, data_next;      // Captured data.
  logic [4:0] len_reg, len_next;        // Frame length kept past the frame.

  assign frameClr = reset | csN;

  // Next values of the receive side; edges while paused are ignored.
  always_comb begin
    bitCnt_next = bitCnt_reg;
    shift_next  = shift_reg;
    instr_next  = instr_reg;
    data_next   = data_reg;
    len_next    = len_reg;
    if (holdN && !csN) begin
      shift_next = {shift_reg[5:0], si};
      if (bitCnt_reg != LEN_OVER) begin
        bitCnt_next = bitCnt_reg + 5'h01;
      end
      len_next = bitCnt_next;
      if (bitCnt_reg == LEN_INSTR - 5'h01) begin
        instr_next = {shift_reg, si};
      end
      if (bitCnt_reg == LEN_DATA - 5'h01) begin
        data_next = {shift_reg, si};
      end
    end
  end

  always_ff @(posedge sck or posedge frameClr) begin
    if (frameClr) begin
      bitCnt_reg <= 5'h00;
      shift_reg  <= 7'h00;
    end else begin
      bitCnt_reg <= bitCnt_next;
      shift_reg  <= shift_next;
    end
  end

  // Captured words survive the frame so the core can act on select rise.
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      instr_reg <= 8'h00;
      data_reg  <= 8'h00;
      len_reg   <= 5'h00;
    end else begin
      instr_reg <= instr_next;
      data_reg  <= data_next;
      len_reg   <= len_next;
    end
  end

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  logic [7:0] soShift_reg, soShift_next;  // Output shifter, MSB first.
  logic       readPh_reg, readPh_next;    // Read data phase.
  logic [2:0] op;                         // Opcode of this frame.
  logic [5:0] readValue;                  // Selected value for a read.
  logic       addrMatch;                  // Straps agree with the address.

  assign op        = instr_reg[OP_POS +: 3];
  assign readValue = (op == OP_READ_SLOT)
                   ? lnk.slotVal[instr_reg[POT_POS]][instr_reg[SLOT_POS +: 2]]
                   : lnk.wiperVal[instr_reg[POT_POS]];
  assign addrMatch = (instr_reg[ADDR_POS +: 2] == lnk.strapAddr);

  // Next values of the transmit side.
  always_comb begin
    soShift_next = soShift_reg;
    readPh_next  = readPh_reg;
    if (holdN) begin
      if (bitCnt_reg == LEN_INSTR) begin
        readPh_next  = addrMatch && (op == OP_READ_WIPER || op == OP_READ_SLOT);
        soShift_next = {2'h0, readValue};
      end else begin
        soShift_next = {soShift_reg[6:0], 1'b0};
        if (bitCnt_reg >= LEN_DATA) begin
          readPh_next = 1'b0;
        end
      end
    end
  end

  always_ff @(negedge sck or posedge frameClr) begin
    if (frameClr) begin
      readPh_reg <= 1'b0;
    end else begin
      readPh_reg <= readPh_next;
    end
  end

  always_ff @(negedge sck or posedge reset) begin
    if (reset) begin
      soShift_reg <= 8'h00;
    end else begin
      soShift_reg <= soShift_next;
    end
  end

  assign lnk.instrByte = instr_reg;
  assign lnk.dataByte  = data_reg;
  assign lnk.frameLen  = len_reg;
  assign lnk.readPhase = readPh_reg;
  assign lnk.soBit     = soShift_reg[7];

  a_bit_count: assert property (@(posedge sck) disable iff (frameClr)
    (holdN && bitCnt_reg < LEN_DATA) |=> (len_reg == $past(bitCnt_reg) + 5'h01))
    else $error("Bit count did not advance on a rising edge.");

endmodule

// ===== design/dpsc_top.sv
// Top of the dual pot serial control front end: core clock sequencer.
// Assumes the link clock is unrelated to clk and stops outside frames.
`timescale 1ns/10ps
module dpsc_top #(
  parameter int unsigned WriteCycles = dpsc_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          sck,
  input  wire logic                          csN,
  input  wire logic                          si,
  output logic                               soOut,
  output logic                               soOeN,
  input  wire logic                          holdN,
  input  wire logic                          wpN,
  input  wire logic                          addrStrapLow,
  input  wire logic                          addrStrapHigh,
  output logic [dpsc_pkg::TAP_COUNT-1:0]     tapSel0,
  output logic [dpsc_pkg::TAP_COUNT-1:0]     tapSel1,
  output logic [dpsc_pkg::WIPER_W-1:0]       wiperPos0,
  output logic [dpsc_pkg::WIPER_W-1:0]       wiperPos1,
  output logic                               writeBusy
);
  import dpsc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot tap decode, used for both pots and for checking.
  function automatic logic [TAP_COUNT-1:0] tapDecode(input logic [WIPER_W-1:0] v);
    tapDecode = 64'h1 << v;
  endfunction

  // ----------------------------------------------------------------
  // Link instance
  // ----------------------------------------------------------------
  dpsc_link_if lnk ();  // Carrier to the link clock logic.

  dpsc_spi_link u_link (
    .sck   (sck),
    .reset (reset),
    .csN   (csN),
    .si    (si),
    .holdN (holdN),
    .lnk   (lnk)
  );

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [5:0] syncA_reg;  // First stage, read only by the second.
  logic [5:0] syncB_reg;  // Second stage: read, straps, pause, protect, select.
  logic       csPrev_reg; // Select one cycle back, for edges.
  logic       wpPrev_reg; // Protect one cycle back, for edges.
  logic       csQ;        // Synchronised select.
  logic       wpQ;        // Synchronised protect.
  logic       holdQ;      // Synchronised pause.
  logic       readQ;      // Synchronised read phase.
  logic       csRise;     // Select just went high.
  logic       csFall;     // Select just went low.
  logic       wpFall;     // Protect just went low.

  // Two flops per pin; the straps and read phase ride the same chain.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA_reg  <= SYNC_RESET;
      syncB_reg  <= SYNC_RESET;
      csPrev_reg <= 1'b1;
      wpPrev_reg <= 1'b1;
    end else begin
      syncA_reg  <= {lnk.readPhase, addrStrapHigh, addrStrapLow, holdN, wpN, csN};
      syncB_reg  <= syncA_reg;
      csPrev_reg <= syncB_reg[0];
      wpPrev_reg <= syncB_reg[1];
    end
  end

  assign csQ    = syncB_reg[0];
  assign wpQ    = syncB_reg[1];
  assign holdQ  = syncB_reg[2];
  assign readQ  = syncB_reg[5];
  assign csRise = csQ & ~csPrev_reg;
  assign csFall = ~csQ & csPrev_reg;
  assign wpFall = ~wpQ & wpPrev_reg;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [2:0] op;      // Opcode of the finished frame.
  logic       pot;     // Pot selected by the frame.
  logic [1:0] slot;    // Slot selected by the frame.
  logic       addrOk;  // Straps match the frame address.
  logic       lenOk;   // Frame length fits the opcode.

  assign op   = lnk.instrByte[OP_POS +: 3];
  assign pot  = lnk.instrByte[POT_POS];
  assign slot = lnk.instrByte[SLOT_POS +: 2];
  assign addrOk = (lnk.instrByte[ADDR_POS +: 2] == syncB_reg[4:3]);
  // Writes of a value need the data byte; recall and store are one byte.
  assign lenOk = (op == OP_WRITE_WIPER || op == OP_WRITE_SLOT) ? (lnk.frameLen == LEN_DATA)
               : (lnk.frameLen == LEN_INSTR);

  // ----------------------------------------------------------------
  // Sequencer and storage
  // ----------------------------------------------------------------
  dpsc_state_t          state_reg, state_next;      // Sequencer state.
  logic [BUSY_W-1:0]    busyCnt_reg, busyCnt_next;  // Write cycle countdown.
  dpsc_wipers_t         wiperPosition_reg, wiperPosition_next;
  dpsc_slots_t          storedSettingSlot_reg, storedSettingSlot_next;
  logic                 abort_reg, abort_next;      // Frame write abandoned.
  logic [TAP_COUNT-1:0] tap0_reg, tap0_next;        // Tap switches, pot 0.
  logic [TAP_COUNT-1:0] tap1_reg, tap1_next;        // Tap switches, pot 1.
  logic                 nvStart;                    // A slot write begins.

  // Next state. Commands act on select rise, after the whole frame is in,
  // so a half-sent frame never disturbs the wiper.
  always_comb begin
    state_next             = state_reg;
    busyCnt_next           = busyCnt_reg;
    wiperPosition_next     = wiperPosition_reg;
    storedSettingSlot_next = storedSettingSlot_reg;
    abort_next             = abort_reg;
    nvStart                = 1'b0;
    case (state_reg)
      ST_RECALL: begin
        for (int p = 0; p < POT_COUNT; p++) begin
          wiperPosition_next[p] = storedSettingSlot_reg[p][0];
        end
        state_next = ST_IDLE;
      end
      // New commands are taken only while no write cycle runs.
      ST_IDLE: begin
        if (csRise && addrOk && lenOk && !abort_reg) begin
          case (op)
            OP_WRITE_WIPER: begin
              wiperPosition_next[pot] = lnk.dataByte[WIPER_W-1:0];
            end
            OP_RECALL: begin
              wiperPosition_next[pot] = storedSettingSlot_reg[pot][slot];
            end
            OP_WRITE_SLOT: begin
              if (wpQ) begin
                storedSettingSlot_next[pot][slot] = lnk.dataByte[WIPER_W-1:0];
                nvStart = 1'b1;
              end
            end
            OP_STORE: begin
              if (wpQ) begin
                storedSettingSlot_next[pot][slot] = wiperPosition_reg[pot];
                nvStart = 1'b1;
              end
            end
            // Reads and unknown opcodes change nothing here.
            default: begin
            end
          endcase
          if (nvStart) begin
            state_next   = ST_BUSY;
            busyCnt_next = BUSY_W'(WriteCycles - 1);
          end
        end
      end
      ST_BUSY: begin
        if (busyCnt_reg == '0) begin
          state_next = ST_IDLE;
        end else begin
          busyCnt_next = busyCnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (csFall) begin
      abort_next = 1'b0;
    end
    if (wpFall && !csQ) begin
      abort_next = 1'b1;
    end
  end

  always_comb begin
    tap0_next = tapDecode(wiperPosition_next[0]);
    tap1_next = tapDecode(wiperPosition_next[1]);
  end

  // Storage stands in for the non-volatile array; reset reloads its default.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg             <= ST_RECALL;
      busyCnt_reg           <= '0;
      wiperPosition_reg     <= '0;
      storedSettingSlot_reg <= {(POT_COUNT * SLOT_COUNT){SLOT_RESET}};
      abort_reg             <= 1'b0;
      tap0_reg              <= 64'h1;
      tap1_reg              <= 64'h1;
    end else begin
      state_reg             <= state_next;
      busyCnt_reg           <= busyCnt_next;
      wiperPosition_reg     <= wiperPosition_next;
      storedSettingSlot_reg <= storedSettingSlot_next;
      abort_reg             <= abort_next;
      tap0_reg              <= tap0_next;
      tap1_reg              <= tap1_next;
    end
  end

  // ----------------------------------------------------------------
  // Output enable and status
  // ----------------------------------------------------------------
  logic soOeN_reg, soOeN_next;  // Low while the output is driven.
  logic busy_reg, busy_next;    // Write cycle in progress.

  // The enable is rebuilt on clk so that pause and select take effect
  // within three core cycles, well inside half a link clock period.
  always_comb begin
    soOeN_next = ~(readQ & holdQ & ~csQ);
    busy_next  = (state_next == ST_BUSY);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soOeN_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      soOeN_reg <= soOeN_next;
      busy_reg  <= busy_next;
    end
  end

  assign lnk.wiperVal  = wiperPosition_reg;
  assign lnk.slotVal   = storedSettingSlot_reg;
  assign lnk.strapAddr = syncB_reg[4:3];
  assign soOut         = lnk.soBit;
  assign soOeN         = soOeN_reg;
  assign tapSel0       = tap0_reg;
  assign tapSel1       = tap1_reg;
  assign wiperPos0     = wiperPosition_reg[0];
  assign wiperPos1     = wiperPosition_reg[1];
  assign writeBusy     = busy_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_recall_first: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_RECALL) |=> (wiperPosition_reg[0] == $past(storedSettingSlot_reg[0][0])
                               && wiperPosition_reg[1] == $past(storedSettingSlot_reg[1][0])))
    else $error("Wiper not loaded from first slot after reset.");

  a_tap_onehot: assert property (@(posedge clk) disable iff (reset)
    (tap0_reg == tapDecode(wiperPosition_reg[0])) && (tap1_reg == tapDecode(wiperPosition_reg[1])))
    else $error("Tap switches disagree with wiper register.");

  a_cs_float: assert property (@(posedge clk) disable iff (reset)
    csQ |=> soOeN_reg)
    else $error("Output driven while select is high.");

  a_hold_float: assert property (@(posedge clk) disable iff (reset)
    !holdQ |=> soOeN_reg)
    else $error("Output driven while paused.");

  a_read_only: assert property (@(posedge clk) disable iff (reset)
    !soOeN_reg |-> $past(readQ))
    else $error("Output driven outside a read phase.");

  // A frame that ends while a write cycle still runs is refused anyway and the
  // sequencer stays busy, so both a new cycle start and any slot change in the next cycle are ruled out here.
  a_protect_slot: assert property (@(posedge clk) disable iff (reset)
    (csRise && !wpQ) |-> !nvStart ##1 $stable(storedSettingSlot_reg))
    else $error("Slot written while protected.");

  a_write_start: assert property (@(posedge clk) disable iff (reset)
    nvStart |=> (state_reg == ST_BUSY) && (busyCnt_reg == BUSY_W'(WriteCycles - 1)))
    else $error("Write cycle did not start on select rise.");

  a_busy_hold: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_BUSY && busyCnt_reg != '0) |=> (state_reg == ST_BUSY)
                                                 && (busyCnt_reg == $past(busyCnt_reg) - 1'b1))
    else $error("Write cycle cut short.");

  a_abort_write: assert property (@(posedge clk) disable iff (reset)
    (abort_reg && csRise) |=> $stable(wiperPosition_reg) && $stable(storedSettingSlot_reg))
    else $error("Abandoned write still took effect.");

  // The enable is held against the pins three core cycles back, which is the
  // depth of the two synchroniser stages plus the enable flop. This catches a
  // chain that is miswired or too short, which the checks above cannot see.
  a_oe_pins: assert property (@(posedge clk) disable iff (reset)
    !soOeN_reg |-> !$past(csN, 3) && $past(holdN, 3))
    else $error("Output driven after select rose or pause fell at the pins.");

endmodule

// ===== tb/dpsc_spi_ctrl.sv
// SPI controller model that sends whole frames in modes (0,0) and (1,1).
// Assumes the bench shows a floating data line as the inverse of its last value.
`timescale 1ns/10ps
module dpsc_spi_ctrl (
  output logic      sck,
  output logic      csN,
  output logic      si,
  output logic      holdN,
  input  wire logic soLine,
  input  wire logic soOeN
);
  initial begin
    sck   = 1'b0;
    csN   = 1'b1;
    si    = 1'b0;
    holdN = 1'b1;
  end

  // One frame, MSB first, with an 80 ns bit period.
  // The odd start offset keeps sck unrelated in phase to clk.
  task automatic xfer(input logic [15:0] w, input int n, input bit m, input int hb,
                      output logic [7:0] rd, output logic oe);
    rd = 8'h00;
    oe = 1'b0;
    sck <= m;
    #37.3 csN <= 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      si  <= w[15-i];
      // Pause and resume only while sck is low.
      if (i == hb) begin
        #40 holdN <= 1'b0;
        #200 oe = soOeN;
        holdN <= 1'b1;
      end
      #40 sck <= 1'b1;
      // Read bits are taken at the rising edge.
      rd = {rd[6:0], soLine};
      #40;
    end
    if (!m) sck <= 1'b0;
    #40 csN <= 1'b1;
    #40;
  endtask
endmodule

// ===== tb/tb_dual_pot_serial_control.sv
// Self-checking bench of the dual pot serial control front end.
// Assumes a 200 MHz core clock and the SPI controller model beside it.
`timescale 1ns/10ps
module tb_dual_pot_serial_control;
  import dpsc_pkg::*;
  logic                 clk = 1'b0;  // Core clock.
  logic                 reset = 1'b1;  // Held for five cycles.
  logic                 wpN = 1'b1;  // Write protect, active low.
  logic                 sck, csN, si, holdN, soOut, soOeN, writeBusy, heldOe;
  logic                 soLast = 1'b0;  // Last driven data bit.
  logic [1:0]           ad = 2'h1;  // Address sent in frames.
  logic [TAP_COUNT-1:0] tapSel0, tapSel1;
  logic [WIPER_W-1:0]   wiperPos0, wiperPos1;
  logic [WIPER_W-1:0]   vv [2];  // Random wiper values per pot.
  logic [7:0]           rd;
  logic [63:0]          obs, e;
  logic [63:0]          notes [$];  // Expected results, oldest first.
  int                   err_total = 0, checks_done = 0, seed = 32'h4021d3bb;
  wire                  soLine;
  event                 seen;

  always #2.5 clk = ~clk;
  // A released line shows the inverse of its last value, never a stale copy.
  always @(posedge clk) if (soOeN === 1'b0) soLast <= soOut;
  assign soLine = (soOeN === 1'b0) ? soOut : ~soLast;

  dpsc_top #(.WriteCycles(20)) u_dpsc_top (.clk(clk), .reset(reset), .sck(sck), .csN(csN), .si(si),
    .soOut(soOut), .soOeN(soOeN), .holdN(holdN), .wpN(wpN), .addrStrapLow(1'b1), .addrStrapHigh(1'b0),
    .tapSel0(tapSel0), .tapSel1(tapSel1), .wiperPos0(wiperPos0), .wiperPos1(wiperPos1),
    .writeBusy(writeBusy));
  dpsc_spi_ctrl u_dpsc_spi_ctrl (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .soLine(soLine),
    .soOeN(soOeN));

  // Writes and reads carry 16 bits, recall and store 8.
  task automatic cmd(input logic [2:0] op, input logic p, input logic [1:0] s, input logic [7:0] d,
                     input bit m, input int hb = -1);
    u_dpsc_spi_ctrl.xfer({op, ad, p, s, d}, (op < 3'h4) ? 16 : 8, m, hb, rd, heldOe);
  endtask

  task automatic chk(input logic [63:0] x, input logic [63:0] g);
    notes.push_back(x);
    obs = g;
    -> seen;
    #1;
  endtask

  // Takes the oldest note whenever a result is shown.
  always @(seen) begin
    e = notes.pop_front();
    checks_done++;
    if (obs !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, obs, e);
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for the end of a write cycle.
  task automatic waitIdle;
    int k;
    k = 0;
    while (writeBusy !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      err_total++;
      complete_run;
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    chk(SLOT_RESET, wiperPos0);
    chk(64'h1 << SLOT_RESET, tapSel1);
    for (int m = 0; m < 2; m++) begin
      vv[m] = 6'($random(seed));
      cmd(OP_WRITE_WIPER, m, 2'h0, vv[m], m);
      chk(vv[m], m ? wiperPos1 : wiperPos0);
      chk(64'h1 << vv[m], m ? tapSel1 : tapSel0);
      cmd(OP_READ_WIPER, m, 2'h0, 8'h00, m);
      chk(vv[m], rd);
    end
    ad = 2'h2;
    cmd(OP_WRITE_WIPER, 1'b0, 2'h0, ~vv[0], 1'b0);
    ad = 2'h1;
    chk(vv[0], wiperPos0);
    @(posedge clk) wpN <= 1'b0;
    cmd(OP_WRITE_SLOT, 1'b0, 2'h1, 8'h15, 1'b0);
    chk(1'b0, writeBusy);
    @(posedge clk) wpN <= 1'b1;
    cmd(OP_READ_SLOT, 1'b0, 2'h1, 8'h00, 1'b1);
    chk(SLOT_RESET, rd);
    cmd(OP_WRITE_SLOT, 1'b0, 2'h1, 8'h15, 1'b0);
    chk(1'b1, writeBusy);
    @(posedge clk) wpN <= 1'b0;
    waitIdle;
    @(posedge clk) wpN <= 1'b1;
    cmd(OP_READ_SLOT, 1'b0, 2'h1, 8'h00, 1'b0, 12);
    chk(8'h15, rd);
    chk(1'b1, heldOe);
    cmd(OP_RECALL, 1'b0, 2'h1, 8'h00, 1'b1);
    chk(6'h15, wiperPos0);
    cmd(OP_STORE, 1'b1, 2'h3, 8'h00, 1'b0);
    waitIdle;
    cmd(OP_READ_SLOT, 1'b1, 2'h3, 8'h00, 1'b0);
    chk(vv[1], rd);
    fork
      cmd(OP_WRITE_WIPER, 1'b0, 2'h0, 8'h3F, 1'b0);
      begin
        #600;
        @(posedge clk) wpN <= 1'b0;
      end
    join
    chk(6'h15, wiperPos0);
    cmd(OP_WRITE_WIPER, 1'b0, 2'h0, 8'h2A, 1'b1);
    chk(6'h2A, wiperPos0);
    chk(1'b1, soOeN);
    complete_run;
  end
endmodule
